/* vbs_pkg.sv */
// Constants for the vertical blank and sync timing block.
// Assumes a one-clock system in which the line counter and register strobes share clk.
// How it works
// - Blanking starts when the line count equals an 11-bit value from the start register and two overflow registers.
// - Blanking ends at the first line after the start line whose low eight bits match the blank end register.
// - Sync starts when the line count equals an 11-bit value from the retrace start register and two overflow registers.
// - The sync output polarity follows bit 7 of the general output register.
// - Sync end is the four-bit field in bits 3:0 of the retrace end register, so sync lasts at most 16 lines.
// - Blank end and retrace start are 8-bit read/write registers, retrace end keeps only its low four bits, all reset to zero.
// - The registers are reached through the indexed data port at 3CF, indices 73, 74 and 75.
// - The extended registers always drive timing; standard-path writes reach them only while the lock bit is clear.
package vbs_pkg;
  localparam logic [15:0] ADDR_INDEX = 16'h03ce;
  localparam logic [15:0] ADDR_DATA = 16'h03cf;
  localparam logic [7:0] IDX_BLANK_START = 8'h72;
  localparam logic [7:0] IDX_BLANK_END = 8'h73;
  localparam logic [7:0] IDX_SYNC_START = 8'h74;
  localparam logic [7:0] IDX_SYNC_END = 8'h75;
  localparam logic [7:0] IDX_OVF_FIRST = 8'h78;
  localparam logic [7:0] IDX_OVF_SECOND = 8'h79;
  localparam logic [7:0] IDX_LOCK = 8'h83;
  // Standard-path indices of the shadowed timing registers
  localparam logic [7:0] STD_OVERFLOW = 8'h07;
  localparam logic [7:0] STD_SYNC_START = 8'h10;
  localparam logic [7:0] STD_SYNC_END = 8'h11;
  localparam logic [7:0] STD_BLANK_START = 8'h15;
  localparam logic [7:0] STD_BLANK_END = 8'h16;
  // Field positions
  localparam int OVF1_BLANK_B8 = 3;
  localparam int OVF1_SYNC_B8 = 2;
  localparam int OVF1_SYNC_B9 = 7;
  localparam int OVF2_BLANK_B9 = 2;
  localparam int OVF2_BLANK_B10 = 3;
  localparam int OVF2_SYNC_B10 = 4;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] SYNC_END_MASK = 8'h0f;
  localparam logic [7:0] OVF2_MASK = 8'h1f;
  localparam logic [7:0] LOCK_MASK = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam int LINE_W = 11;
endpackage

/* vbs_tim_if.sv */
// Carrier between the register side and the line comparator.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface vbs_tim_if;
  import vbs_pkg::*;
  logic line_tick;
  logic [LINE_W-1:0] line_count;
  logic [LINE_W-1:0] blank_start;
  logic [7:0] blank_end;
  logic [LINE_W-1:0] sync_start;
  logic [3:0] sync_end;
  logic blank_active;
  logic sync_active;
  modport ctl (output line_tick, line_count, blank_start, blank_end, sync_start, sync_end,
    input blank_active, sync_active);
  modport cmp (input line_tick, line_count, blank_start, blank_end, sync_start, sync_end,
    output blank_active, sync_active);
endinterface

/* vbs_compare.sv */
// Line comparator: raises and drops blanking and sync on each scanline tick.
// Assumes line_tick marks a new value of line_count, both from clk-domain logic.
`timescale 1ns/100ps
module vbs_compare (
  input wire logic clk,
  input wire logic rst_n,
  vbs_tim_if.cmp tim
);
  import vbs_pkg::*;

  wire blank_hit = tim.line_count == tim.blank_start;
  wire blank_stop = tim.line_count[7:0] == tim.blank_end;
  wire sync_hit = tim.line_count == tim.sync_start;
  wire sync_stop = tim.line_count[3:0] == tim.sync_end;
  // Start wins over end on the same line, so a zero-width setting gives 256 lines of blanking and 16 of sync
  wire next_blank = blank_hit ? 1'b1 : (blank_stop ? 1'b0 : tim.blank_active);
  wire next_sync = sync_hit ? 1'b1 : (sync_stop ? 1'b0 : tim.sync_active);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tim.blank_active <= 1'b0;
      tim.sync_active <= 1'b0;
    end else if (tim.line_tick) begin
      tim.blank_active <= next_blank;
      tim.sync_active <= next_sync;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  blank_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    tim.line_tick && blank_hit |=> tim.blank_active)
    else $error("blanking did not start at blank start line");
  blank_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    tim.line_tick && !blank_hit && blank_stop |=> !tim.blank_active)
    else $error("blanking did not end at blank end match");
  sync_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    tim.line_tick && sync_hit |=> tim.sync_active)
    else $error("sync did not start at retrace start line");
  sync_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    tim.line_tick && tim.sync_active && !sync_hit && sync_stop |=> !tim.sync_active)
    else $error("sync did not end at retrace end match");
  idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tim.line_tick |=> $stable(tim.sync_active) && $stable(tim.blank_active))
    else $error("timing state changed without a line tick");
  blank_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(tim.blank_active) ##[1:1000] $fell(tim.blank_active));
  sync_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(tim.sync_active) ##[1:1000] $fell(tim.sync_active));
endmodule // vbs_compare

/* vbs_top.sv */
// Vertical blank and sync timing with its extended register set.
// Assumes one-cycle io_wr/io_rd strobes and line_tick from same-clock logic.
`timescale 1ns/100ps
module vbs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic std_wr,
  input wire logic [7:0] std_index,
  input wire logic [7:0] std_wdata,
  input wire logic misc_vsync_pol,
  input wire logic line_tick,
  input wire logic [vbs_pkg::LINE_W-1:0] line_count,
  output logic vblank_out,
  output logic vsync_out
);
  import vbs_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] index_reg;
  logic [7:0] vert_blank_start_low;
  logic [7:0] vert_blank_end_value;
  logic [7:0] vert_sync_start_low;
  logic [7:0] vert_sync_end_value;
  logic [7:0] vert_overflow_first;
  logic [7:0] vert_overflow_second;
  logic [7:0] timing_set_lock_reg;

  wire index_wr = io_wr && io_addr == ADDR_INDEX;
  wire data_wr = io_wr && io_addr == ADDR_DATA;
  wire data_rd = io_rd && io_addr == ADDR_DATA;
  wire index_rd = io_rd && io_addr == ADDR_INDEX;
  // Standard path is shut off while the lock bit is set
  wire std_open = std_wr && !timing_set_lock_reg[LOCK_BIT];

  // Extension writes take priority over a same-cycle standard write
  wire wr_bs = data_wr && index_reg == IDX_BLANK_START;
  wire wr_be = data_wr && index_reg == IDX_BLANK_END;
  wire wr_ss = data_wr && index_reg == IDX_SYNC_START;
  wire wr_se = data_wr && index_reg == IDX_SYNC_END;
  wire wr_o1 = data_wr && index_reg == IDX_OVF_FIRST;
  wire wr_o2 = data_wr && index_reg == IDX_OVF_SECOND;
  wire wr_lk = data_wr && index_reg == IDX_LOCK;
  wire sw_bs = std_open && std_index == STD_BLANK_START;
  wire sw_be = std_open && std_index == STD_BLANK_END;
  wire sw_ss = std_open && std_index == STD_SYNC_START;
  wire sw_se = std_open && std_index == STD_SYNC_END;
  wire sw_o1 = std_open && std_index == STD_OVERFLOW;

  wire [7:0] next_bs = wr_bs ? io_wdata : (sw_bs ? std_wdata : vert_blank_start_low);
  wire [7:0] next_be = wr_be ? io_wdata : (sw_be ? std_wdata : vert_blank_end_value);
  wire [7:0] next_ss = wr_ss ? io_wdata : (sw_ss ? std_wdata : vert_sync_start_low);
  wire [7:0] next_se = wr_se ? (io_wdata & SYNC_END_MASK)
    : (sw_se ? (std_wdata & SYNC_END_MASK) : vert_sync_end_value);
  wire [7:0] next_o1 = wr_o1 ? io_wdata : (sw_o1 ? std_wdata : vert_overflow_first);
  wire [7:0] next_o2 = wr_o2 ? (io_wdata & OVF2_MASK) : vert_overflow_second;
  wire [7:0] next_lk = wr_lk ? (io_wdata & LOCK_MASK) : timing_set_lock_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      index_reg <= REG_RESET;
      vert_blank_start_low <= REG_RESET;
      vert_blank_end_value <= REG_RESET;
      vert_sync_start_low <= REG_RESET;
      vert_sync_end_value <= REG_RESET;
      vert_overflow_first <= REG_RESET;
      vert_overflow_second <= REG_RESET;
      timing_set_lock_reg <= REG_RESET;
    end else begin
      if (index_wr) begin
        index_reg <= io_wdata;
      end
      vert_blank_start_low <= next_bs;
      vert_blank_end_value <= next_be;
      vert_sync_start_low <= next_ss;
      vert_sync_end_value <= next_se;
      vert_overflow_first <= next_o1;
      vert_overflow_second <= next_o2;
      timing_set_lock_reg <= next_lk;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped indices read as zero rather than echoing a stale register
  wire sel_bs = index_reg == IDX_BLANK_START;
  wire sel_be = index_reg == IDX_BLANK_END;
  wire sel_ss = index_reg == IDX_SYNC_START;
  wire sel_se = index_reg == IDX_SYNC_END;
  wire sel_o1 = index_reg == IDX_OVF_FIRST;
  wire sel_o2 = index_reg == IDX_OVF_SECOND;
  wire sel_lk = index_reg == IDX_LOCK;
  wire [7:0] rd_sel = sel_bs ? vert_blank_start_low
    : sel_be ? vert_blank_end_value
    : sel_ss ? vert_sync_start_low
    : sel_se ? vert_sync_end_value
    : sel_o1 ? vert_overflow_first
    : sel_o2 ? vert_overflow_second
    : sel_lk ? timing_set_lock_reg
    : REG_RESET;
  wire [7:0] next_rdata = index_rd ? index_reg : (data_rd ? rd_sel : io_rdata);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_rdata <= REG_RESET;
    end else begin
      io_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  vbs_tim_if tim ();
  assign tim.line_tick = line_tick;
  assign tim.line_count = line_count;
  assign tim.blank_start = {vert_overflow_second[OVF2_BLANK_B10],
    vert_overflow_second[OVF2_BLANK_B9], vert_overflow_first[OVF1_BLANK_B8],
    vert_blank_start_low};
  assign tim.blank_end = vert_blank_end_value;
  assign tim.sync_start = {vert_overflow_second[OVF2_SYNC_B10],
    vert_overflow_first[OVF1_SYNC_B9], vert_overflow_first[OVF1_SYNC_B8],
    vert_sync_start_low};
  assign tim.sync_end = vert_sync_end_value[3:0];

  vbs_compare vbs_compare_inst (
    .clk(clk),
    .rst_n(rst_n),
    .tim(tim)
  );

  // Polarity bit set means an active-low sync pulse at the pin
  wire next_vsync = tim.sync_active ^ misc_vsync_pol;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vblank_out <= 1'b0;
      vsync_out <= 1'b0;
    end else begin
      vblank_out <= tim.blank_active;
      vsync_out <= next_vsync;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sync_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 vsync_out == ($past(tim.sync_active) ^ $past(misc_vsync_pol)))
    else $error("sync output polarity wrong");
  end_field_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_se |=> vert_sync_end_value == ($past(io_wdata) & SYNC_END_MASK))
    else $error("retrace end register kept upper bits");
  lock_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_wr && timing_set_lock_reg[LOCK_BIT] && !data_wr
    |=> $stable(vert_blank_end_value) && $stable(vert_sync_start_low))
    else $error("standard write reached locked registers");
  std_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_wr && !timing_set_lock_reg[LOCK_BIT] && !data_wr && std_index == STD_BLANK_END
    |=> vert_blank_end_value == $past(std_wdata))
    else $error("standard write did not update unlocked register");
  read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    data_rd && index_reg == IDX_BLANK_END && !data_wr
    |=> io_rdata == $past(vert_blank_end_value))
    else $error("indexed read returned wrong value");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  // Reset values are checked without the disable, since reset is the trigger
  reg_reset_a: assert property (@(posedge clk)
    !rst_n
    |=> vert_blank_end_value == REG_RESET && vert_sync_start_low == REG_RESET
      && vert_sync_end_value == REG_RESET)
    else $error("timing registers not cleared by reset");
  index_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    index_rd
    |=> io_rdata == $past(index_reg))
    else $error("index port read returned wrong index");
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !index_rd && !data_rd
    |=> $stable(io_rdata))
    else $error("read data moved without a decoded read");
  se_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vert_sync_end_value & ~SYNC_END_MASK) == REG_RESET)
    else $error("retrace end register holds upper bits");
  ovf2_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_o2
    |=> vert_overflow_second == ($past(io_wdata) & OVF2_MASK))
    else $error("second overflow register kept reserved bits");
  lock_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_lk
    |=> timing_set_lock_reg == ($past(io_wdata) & LOCK_MASK))
    else $error("lock register kept unused bits");
  // The extension path writes even when a standard write lands in the same cycle
  ext_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    data_wr && index_reg == IDX_SYNC_START
    |=> vert_sync_start_low == $past(io_wdata))
    else $error("extension write lost to the standard path");
  std_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_wr && !timing_set_lock_reg[LOCK_BIT] && !data_wr && std_index == STD_SYNC_END
    |=> vert_sync_end_value == ($past(std_wdata) & SYNC_END_MASK))
    else $error("standard write did not reach unlocked retrace end");
  std_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_wr && !timing_set_lock_reg[LOCK_BIT] && !data_wr && std_index == STD_OVERFLOW
    |=> vert_overflow_first == $past(std_wdata))
    else $error("standard write did not reach unlocked overflow");
  lock_rest_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_wr && timing_set_lock_reg[LOCK_BIT] && !data_wr
    |=> $stable(vert_sync_end_value) && $stable(vert_blank_start_low)
      && $stable(vert_overflow_first))
    else $error("standard write reached other locked registers");
  lock_set_c: cover property (@(posedge clk) disable iff (!rst_n)
    timing_set_lock_reg[LOCK_BIT] && std_wr);
  sync_pin_c: cover property (@(posedge clk) disable iff (!rst_n) $changed(vsync_out));
endmodule // vbs_top

/* vbs_crt_monitor.sv */
// CRT monitor model: measures each vertical sync pulse in scanlines.
// Assumes line ticks from the bench at least three clocks apart.
`timescale 1ns/100ps
module vbs_crt_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_tick,
  input wire logic vsync_pin,
  input wire logic pol,
  output logic [7:0] sync_lines
);
  // ----------------------------------------------------------------
  // Pulse width
  // ----------------------------------------------------------------
  logic [7:0] run;
  // The pin level is undone with the same polarity the device applies
  wire logic sync_on = vsync_pin ^ pol;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run <= 8'h00;
      sync_lines <= 8'h00;
    end else if (line_tick && sync_on) begin
      run <= run + 8'h01;
    end else if (!sync_on && run != 8'h00) begin
      sync_lines <= run;
      run <= 8'h00;
    end
  end
endmodule // vbs_crt_monitor

/* vertical_blank_sync_timing_test.sv */
// Self-checking bench for vbs_top with a CRT monitor model.
// Assumes the registers are reached through the index and data ports and the standard write path.
`timescale 1ns/100ps
module vertical_blank_sync_timing_test;
  import vbs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic std_wr = 1'b0;
  logic [7:0] std_index = 8'h00;
  logic [7:0] std_wdata = 8'h00;
  logic pol = 1'b0;
  logic line_tick = 1'b0;
  logic [10:0] line_count = 11'h000;
  logic vblank_out;
  logic vsync_out;
  logic [7:0] sync_lines;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] idx_t [6] = '{8'h73, 8'h74, 8'h75, 8'h79, 8'h83, 8'h76};
  logic [7:0] exp_t [6] = '{8'ha5, 8'hff, 8'h0f, 8'h1f, 8'h01, 8'h00};
  // Blank 0x70a..0x72a, sync 0x712 for three lines
  logic [7:0] pidx_t [6] = '{8'h72, 8'h78, 8'h79, 8'h73, 8'h74, 8'h75};
  logic [7:0] pval_t [6] = '{8'h0a, 8'h8c, 8'h1c, 8'h2a, 8'h12, 8'h05};
  logic [10:0] ln_t [12] = '{11'h60a, 11'h30a, 11'h70a, 11'h612, 11'h512, 11'h312,
    11'h712, 11'h713, 11'h714, 11'h715, 11'h705, 11'h72a};
  logic [11:0] eb_v = 12'h7fc;
  logic [11:0] es_v = 12'h1c0;

  always #2.5 clk = ~clk;

  vbs_top vbs_top_inst (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .std_wr(std_wr),
    .std_index(std_index), .std_wdata(std_wdata), .misc_vsync_pol(pol),
    .line_tick(line_tick), .line_count(line_count), .vblank_out(vblank_out),
    .vsync_out(vsync_out));
  vbs_crt_monitor vbs_crt_monitor_inst (.clk(clk), .rst_n(rst_n), .line_tick(line_tick),
    .vsync_pin(vsync_out), .pol(pol), .sync_lines(sync_lines));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic io_cycle(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= w;
    io_rd <= !w;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    io_cycle(ADDR_INDEX, 1'b1, idx);
    io_cycle(ADDR_DATA, 1'b1, d);
  endtask
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    io_cycle(ADDR_INDEX, 1'b1, idx);
    io_cycle(ADDR_DATA, 1'b0, 8'h00);
    @(posedge clk);
    check(11'(io_rdata), 11'(exp));
  endtask
  task automatic std_write(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    std_wr <= 1'b1;
    std_index <= idx;
    std_wdata <= d;
    @(posedge clk);
    std_wr <= 1'b0;
  endtask
  // Outputs settle one edge after the tick is taken; the check waits two edges
  task automatic line(input logic [10:0] n, input logic eb, input logic es);
    @(posedge clk);
    line_tick <= 1'b1;
    line_count <= n;
    @(posedge clk);
    line_tick <= 1'b0;
    repeat (2) @(posedge clk);
    check(11'(vblank_out), 11'(eb));
    check(11'(vsync_out), 11'(es ^ pol));
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(11'(vblank_out), 11'h000);
    check(11'(vsync_out), 11'h000);
    for (int i = 0; i < 3; i++) rd_reg(idx_t[i], 8'h00);
    for (int i = 0; i < 6; i++) wr_reg(idx_t[i], (i == 0) ? 8'ha5 : 8'hff);
    // Odd foreign address: a decoder that looks at bit 0 alone would hit the data port
    io_cycle(ADDR_INDEX, 1'b1, IDX_BLANK_END);
    io_cycle(16'h03d5, 1'b1, 8'h00);
    for (int i = 0; i < 6; i++) rd_reg(idx_t[i], exp_t[i]);
    wr_reg(IDX_LOCK, 8'h00);
    std_write(STD_BLANK_END, 8'h55);
    rd_reg(IDX_BLANK_END, 8'h55);
    io_cycle(ADDR_INDEX, 1'b0, 8'h00);
    @(posedge clk);
    check(11'(io_rdata), 11'(IDX_BLANK_END));
    std_write(STD_SYNC_END, 8'hf7);
    rd_reg(IDX_SYNC_END, 8'h07);
    std_write(STD_OVERFLOW, 8'h5a);
    rd_reg(IDX_OVF_FIRST, 8'h5a);
    wr_reg(IDX_LOCK, 8'h01);
    std_write(STD_BLANK_END, 8'h66);
    rd_reg(IDX_BLANK_END, 8'h55);
    for (int i = 0; i < 6; i++) wr_reg(pidx_t[i], pval_t[i]);
    for (int i = 0; i < 12; i++) line(ln_t[i], eb_v[i], es_v[i]);
    check(11'(sync_lines), 11'h003);
    wr_reg(IDX_SYNC_END, 8'hf2);
    rd_reg(IDX_SYNC_END, 8'h02);
    for (int i = 0; i < 16; i++) line(11'h712 + 11'(i), 1'b0, 1'b1);
    line(11'h722, 1'b0, 1'b0);
    // The monitor latches its count on the edge after the pin falls
    @(posedge clk);
    check(11'(sync_lines), 11'h010);
    pol <= 1'b1;
    repeat (2) @(posedge clk);
    check(11'(vsync_out), 11'h001);
    line(11'h712, 1'b0, 1'b1);
    line(11'h722, 1'b0, 1'b0);
    @(posedge clk);
    check(11'(sync_lines), 11'h001);
    tally_and_finish();
  end
endmodule // vertical_blank_sync_timing_test
